//--- rtl/xover_pkg.sv
/*
  constants for the per-port crossover and special control register block.
  assumes an ahb-lite master with 32-bit single word transfers.
*/
package xover_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] XOVER_CTRL_INDEX = 8'h1B;
  localparam logic [9:0] XOVER_CTRL_ADDR = {XOVER_CTRL_INDEX, 2'b00};
  localparam int SRC_SEL_BIT = 15;
  localparam int AUTO_EN_BIT = 14;
  localparam int MAN_STATE_BIT = 13;
  localparam int HB_DIS_BIT = 11;
  localparam int PLL_REF_BIT = 10;
  localparam int POL_BIT = 4;
  localparam logic [15:0] WRITE_MASK = 16'hEC00;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] POL_MASK = 16'h0010;
  localparam logic [31:0] RSVD_RD_MASK = 32'hFFFF13EF;
  // edges after reset release before the strap pins are trusted
  localparam int STRAP_SETTLE = 4;
  // ----------------------------------------
  // crossover modes
  // ----------------------------------------
  typedef enum logic [1:0] {
    XO_MANUAL_STRAIGHT = 2'h0,
    XO_MANUAL_CROSS = 2'h1,
    XO_AUTO = 2'h2,
    XO_RESERVED = 2'h3
  } xover_mode_t;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
endpackage

//--- rtl/pin_sync.sv
/*
  three-stage synchroniser with agreement filter for slow pin levels.
  assumes the input is quasi-static compared with the clock.
*/
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] s1_q, s2_q, s3_q;
  logic [WIDTH-1:0] out_d;
  // ----------------------------------------
  // an output bit follows once stages two and three agree
  // ----------------------------------------
  assign out_d = (s2_q & s3_q) | (dout & (s2_q | s3_q));
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      dout <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      dout <= out_d;
    end
  end
endmodule

//--- rtl/xover_ctrl.sv
/*
  crossover and special control register of one port phy, ahb-lite slave.
  assumes one ahb-lite master, word accesses, straps and polarity as pins.
*/
// Added by the designer: the AHB-Lite slave port.
module xover_ctrl (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // ahb-lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // straps and line status pins
  input wire logic MANUAL_XOVER_STRAP,
  input wire logic AUTO_XOVER_STRAP,
  input wire logic POLARITY_REVERSED,
  // port reset request and soft reset enable
  input wire logic PORT_RESET_PULSE,
  input wire logic SOFT_RESET_BIT,
  // controls to the phy
  output logic [1:0] XOVER_MODE,
  output logic HEARTBEAT_TEST_EN,
  output logic RX_PLL_REF_LOCK,
  output logic RX_10M_ALLOW
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] pins_s;
  pin_sync #(.WIDTH(3)) u_sync (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .din({POLARITY_REVERSED, AUTO_XOVER_STRAP, MANUAL_XOVER_STRAP}),
    .dout(pins_s)
  );
  wire manual_strap = pins_s[0];
  wire auto_strap = pins_s[1];
  wire tenbase_polarity_reversed = pins_s[2];

  // ----------------------------------------
  // strap latch once the synchronisers have settled
  // ----------------------------------------
  localparam int SETTLE_TOP = xover_pkg::STRAP_SETTLE - 1;
  logic strap_seen_q;
  logic [1:0] strap_mode_q;
  logic [SETTLE_TOP:0] settle_q;
  wire settle_done = settle_q[SETTLE_TOP];

  // same priority for straps and register bits: automatic wins
  function automatic logic [1:0] pick_mode(input logic auto_bit,
      input logic cross_bit);
    logic [1:0] m;
    if (auto_bit) begin
      m = xover_pkg::XO_AUTO;
    end else if (cross_bit) begin
      m = xover_pkg::XO_MANUAL_CROSS;
    end else begin
      m = xover_pkg::XO_MANUAL_STRAIGHT;
    end
    return m;
  endfunction

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      settle_q <= '0;
    end else begin
      settle_q <= {settle_q[SETTLE_TOP-1:0], 1'b1};
    end
  end
  wire strap_take = settle_done && !strap_seen_q;
  wire [1:0] strap_mode_d = pick_mode(auto_strap, manual_strap);
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      strap_seen_q <= 1'b0;
      strap_mode_q <= 2'h0;
    end else if (strap_take) begin
      strap_seen_q <= 1'b1;
      strap_mode_q <= strap_mode_d;
    end
  end

  // ----------------------------------------
  // ahb-lite address phase capture
  // ----------------------------------------
  logic wr_pend_q;
  logic rd_pend_q;
  logic hit_q;
  wire valid_tr = HSEL && HREADY && HTRANS[1];
  wire addr_hit = (HADDR[9:0] == xover_pkg::XOVER_CTRL_ADDR)
      && (HADDR[31:10] == 22'h000000);
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      hit_q <= 1'b0;
    end else begin
      wr_pend_q <= valid_tr && HWRITE;
      rd_pend_q <= valid_tr && !HWRITE;
      hit_q <= valid_tr && addr_hit;
    end
  end

  // ----------------------------------------
  // control register
  // ----------------------------------------
  logic [15:0] ctrl_q;
  logic [15:0] ctrl_d;
  wire do_write = wr_pend_q && hit_q;
  // port reset takes effect only with soft-reset bit set
  wire port_restore = PORT_RESET_PULSE && SOFT_RESET_BIT;
  // reserved bits never stored
  wire [15:0] wr_val = HWDATA[15:0] & xover_pkg::WRITE_MASK;
  assign ctrl_d = port_restore ? xover_pkg::CTRL_RESET :
      (do_write ? wr_val : ctrl_q);
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_q <= xover_pkg::CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ----------------------------------------
  // read data, registered at the address phase
  // ----------------------------------------
  logic [31:0] rdata_q;
  logic ready_q;
  logic resp_q;
  wire rd_take = valid_tr && !HWRITE && addr_hit;
  // a write landing at the same edge is forwarded
  wire [15:0] stored_view = ctrl_d & xover_pkg::WRITE_MASK;
  wire [15:0] pol_view = xover_pkg::POL_MASK &
      {16{tenbase_polarity_reversed}};
  wire [15:0] rd_view = stored_view | pol_view;
  wire [31:0] rdata_d = rd_take ? {16'h0000, rd_view} : '0;
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_q <= '0;
      ready_q <= 1'b1;
      resp_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      ready_q <= 1'b1;
      resp_q <= 1'b0;
    end
  end
  assign HRDATA = rdata_q;
  assign HREADYOUT = ready_q;
  assign HRESP = resp_q;

  // ----------------------------------------
  // crossover mode selection
  // ----------------------------------------
  wire src_reg = ctrl_q[xover_pkg::SRC_SEL_BIT];
  wire [1:0] reg_mode = {ctrl_q[xover_pkg::AUTO_EN_BIT],
      ctrl_q[xover_pkg::MAN_STATE_BIT]};
  // reserved code 11 can be stored by a software write; treat as automatic
  wire [1:0] reg_mode_safe = pick_mode(reg_mode[1],
      reg_mode[0]);
  wire [1:0] mode_d = src_reg ? reg_mode_safe
      : strap_mode_q;
  wire hb_en_d = !ctrl_q[xover_pkg::HB_DIS_BIT];
  wire pll_ref_d = ctrl_q[xover_pkg::PLL_REF_BIT];
  wire rx_allow_d = !pll_ref_d;
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      XOVER_MODE <= xover_pkg::XO_MANUAL_STRAIGHT;
      HEARTBEAT_TEST_EN <= 1'b1;
      RX_PLL_REF_LOCK <= 1'b0;
      RX_10M_ALLOW <= 1'b1;
    end else begin
      XOVER_MODE <= mode_d;
      HEARTBEAT_TEST_EN <= hb_en_d;
      RX_PLL_REF_LOCK <= pll_ref_d;
      RX_10M_ALLOW <= rx_allow_d;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_write_hit;
    do_write && !port_restore;
  endsequence

  sequence s_reg_ctrl;
    src_reg && reg_mode != xover_pkg::XO_RESERVED;
  endsequence

  sequence s_strap_ctrl;
    !src_reg;
  endsequence

  sequence s_read_phase;
    rd_pend_q && hit_q;
  endsequence

  sequence s_idle_reg;
    !do_write && !port_restore;
  endsequence

  sequence s_restore_refused;
    PORT_RESET_PULSE && !SOFT_RESET_BIT && !do_write;
  endsequence

  a_mode_from_reg: assert property (@(posedge CORE_CLK)
    disable iff (!RST_N) s_reg_ctrl |=> XOVER_MODE == $past(reg_mode))
    else $error("register crossover mode not applied");

  a_mode_from_strap: assert property (@(posedge CORE_CLK)
    disable iff (!RST_N) s_strap_ctrl |=> XOVER_MODE == $past(strap_mode_q))
    else $error("strap crossover mode not applied");

  a_auto_code: assert property (@(posedge CORE_CLK)
    disable iff (!RST_N) src_reg && reg_mode == xover_pkg::XO_AUTO
    |=> XOVER_MODE == xover_pkg::XO_AUTO)
    else $error("automatic code not honoured");

  a_reserved_code: assert property (@(posedge CORE_CLK)
    disable iff (!RST_N) src_reg && reg_mode == xover_pkg::XO_RESERVED
    |=> XOVER_MODE == xover_pkg::XO_AUTO)
    else $error("reserved code not mapped to automatic");

  a_mode_legal: assert property (@(posedge CORE_CLK)
    disable iff (!RST_N) XOVER_MODE != xover_pkg::XO_RESERVED)
    else $error("reserved crossover mode driven");

  a_heartbeat_ctrl: assert property (@(posedge CORE_CLK)
    disable iff (!RST_N) s_write_hit ##1 1'b1
    |=> HEARTBEAT_TEST_EN == !$past(HWDATA[xover_pkg::HB_DIS_BIT], 2))
    else $error("heartbeat control wrong");

  a_heartbeat_follow: assert property (@(posedge CORE_CLK)
    disable iff (!RST_N)
    1'b1 |=> HEARTBEAT_TEST_EN == !$past(ctrl_q[xover_pkg::HB_DIS_BIT]))
    else $error("heartbeat output does not follow register");

  a_pll_lock: assert property (@(posedge CORE_CLK)
    disable iff (!RST_N) RX_PLL_REF_LOCK |-> !RX_10M_ALLOW)
    else $error("10M receive allowed while pll forced");

  a_pll_force: assert property (@(posedge CORE_CLK)
    disable iff (!RST_N) ctrl_q[xover_pkg::PLL_REF_BIT]
    |=> RX_PLL_REF_LOCK && !RX_10M_ALLOW)
    else $error("pll not forced onto reference");

  a_pll_free: assert property (@(posedge CORE_CLK)
    disable iff (!RST_N) !ctrl_q[xover_pkg::PLL_REF_BIT]
    |=> !RX_PLL_REF_LOCK && RX_10M_ALLOW)
    else $error("pll not released");

  a_polarity_rd: assert property (@(posedge CORE_CLK)
    disable iff (!RST_N) s_read_phase
    |-> HRDATA[xover_pkg::POL_BIT] == $past(tenbase_polarity_reversed))
    else $error("polarity bit wrong");

  a_rdata_idle: assert property (@(posedge CORE_CLK)
    disable iff (!RST_N) !(rd_pend_q && hit_q) |-> HRDATA == '0)
    else $error("read data outside a read data phase");

  a_port_restore: assert property (@(posedge CORE_CLK)
    disable iff (!RST_N) port_restore |=> ctrl_q == xover_pkg::CTRL_RESET)
    else $error("port reset did not restore");

  a_restore_refused: assert property (@(posedge CORE_CLK)
    disable iff (!RST_N) s_restore_refused |=> $stable(ctrl_q))
    else $error("port reset acted without soft-reset bit");

  a_write_mask: assert property (@(posedge CORE_CLK)
    disable iff (!RST_N) s_write_hit
    |=> ctrl_q == ($past(HWDATA[15:0]) & xover_pkg::WRITE_MASK))
    else $error("write not stored through mask");

  a_reg_hold: assert property (@(posedge CORE_CLK)
    disable iff (!RST_N) s_idle_reg |=> $stable(ctrl_q))
    else $error("register changed without a write");

  a_reserved_zero: assert property (@(posedge CORE_CLK)
    disable iff (!RST_N) (HRDATA & xover_pkg::RSVD_RD_MASK) == '0)
    else $error("reserved bits not zero");

  a_bus_okay: assert property (@(posedge CORE_CLK)
    disable iff (!RST_N) HREADYOUT && !HRESP)
    else $error("bus answer not ready and okay");

  a_strap_once: assert property (@(posedge CORE_CLK)
    disable iff (!RST_N) strap_seen_q |=> $stable(strap_mode_q))
    else $error("strap mode changed after latching");

  a_strap_pick: assert property (@(posedge CORE_CLK)
    disable iff (!RST_N) strap_take |=> strap_mode_q == $past(strap_mode_d))
    else $error("strap mode not latched");
endmodule

//--- tb/xover_ctrl_tb_top.sv
/*
  self-checking bench for the crossover control register block.
  assumes xover_ctrl as a zero-wait ahb-lite slave with pin synchronisers.
*/
module xover_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // ------------------------------
  // signals and instance
  // ------------------------------
  logic clk, rst_n, hsel, hwrite, man_strap, auto_strap, pol;
  logic port_rst, soft_rst, hb_en, pll_ref, rx_allow, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, mode;
  logic [2:0] hsize;
  int bad_count, samples_checked;
  localparam logic [31:0] ADDR = {22'h0, xover_pkg::XOVER_CTRL_ADDR};
  xover_ctrl i_xover_ctrl (.CORE_CLK(clk), .RST_N(rst_n), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
    .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .MANUAL_XOVER_STRAP(man_strap),
    .AUTO_XOVER_STRAP(auto_strap), .POLARITY_REVERSED(pol),
    .PORT_RESET_PULSE(port_rst), .SOFT_RESET_BIT(soft_rst),
    .XOVER_MODE(mode), .HEARTBEAT_TEST_EN(hb_en),
    .RX_PLL_REF_LOCK(pll_ref), .RX_10M_ALLOW(rx_allow));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ------------------------------
  // bus and check tasks
  // ------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      bad_count++;
      $display("FAIL t=%0t bus wait ran out", $time);
      end_of_test();
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a,
    input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= xover_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(x, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask
  // outputs follow the register one edge after the store
  task automatic out_chk(input logic [4:0] exp);
    tick(2);
    chk({27'h0, mode, hb_en, pll_ref, rx_allow}, {27'h0, exp});
  endtask
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic t_reset();
    out_chk(5'b01101);
    rd_chk(ADDR, 32'h0);
  endtask
  task automatic t_fields();
    wr(ADDR, 32'h0000DFFF);
    rd_chk(ADDR, 32'h0000CC00);
    out_chk(5'b10010);
  endtask
  task automatic t_modes();
    for (int m = 0; m < 3; m++) begin
      wr(ADDR, {16'h0, 1'b1, 2'(m), 13'h0});
      out_chk({2'(m), 3'b101});
    end
    wr(ADDR, 32'h0);
    out_chk(5'b01101);
  endtask
  task automatic t_polarity();
    pol <= 1'b1;
    tick(8);
    rd_chk(ADDR, 32'h00000010);
    wr(ADDR, 32'h00000010);
    pol <= 1'b0;
    tick(8);
    rd_chk(ADDR, 32'h0);
  endtask
  task automatic t_port_reset();
    wr(ADDR, 32'h0000CC00);
    port_rst <= 1'b1;
    tick(1);
    port_rst <= 1'b0;
    rd_chk(ADDR, 32'h0000CC00);
    soft_rst <= 1'b1;
    port_rst <= 1'b1;
    tick(1);
    port_rst <= 1'b0;
    soft_rst <= 1'b0;
    rd_chk(ADDR, 32'h0);
    out_chk(5'b01101);
  endtask
  task automatic t_unmapped();
    wr(32'h00000070, 32'h0000DFFF);
    rd_chk(32'h00000070, 32'h0);
    rd_chk(ADDR, 32'h0);
  endtask
  initial begin
    {rst_n, hsel, hwrite, port_rst, soft_rst, auto_strap, pol} = 7'h00;
    {haddr, hwdata, htrans, hsize, man_strap} = {64'h0, 2'h0, 3'h2, 1'b1};
    bad_count = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    tick(8);
    t_reset();
    t_fields();
    t_modes();
    t_polarity();
    t_port_reset();
    t_unmapped();
    end_of_test();
  end
endmodule
